/* adapter_status_reset_ports.sv */
// Host status word, reset port and channel attention logic of the adapter.
`timescale 1ns/100ps
module adapter_status_reset_ports
   import adapter_status_pkg::*;
   #(
      parameter logic [7:0]  BOARD_TYPE          = 8'h5a,  // Arbitrary value, not a real product code.
      parameter logic [31:0] SELFTEST_CYCLES     = SELFTEST_CYCLES_DEF,
      parameter logic [31:0] XFER_TIMEOUT_CYCLES = XFER_TIMEOUT_CYCLES_DEF,
      parameter int unsigned IDX_W               = 8
   )
   (
      // Clock and reset.
      input  wire logic                   clk_sys_i,
      input  wire logic                   rst_i,
      // Host port pins, asynchronous to the board clock.
      input  wire logic                   host_strobe_i,
      input  wire logic                   host_write_i,
      input  wire logic [HOST_ADDR_W-1:0] host_addr_i,
      input  wire logic [HOST_DATA_W-1:0] host_data_i,
      output logic      [HOST_DATA_W-1:0] host_data_o,
      output logic                        host_data_oe_o,
      output logic                        host_ack_o,
      // Configuration jumper pin.
      input  wire logic                   scsi_reset_jumper_i,
      // Firmware side: self-test progress.
      input  wire logic                   stc_we_i,
      input  wire logic [7:0]             stc_code_i,
      input  wire logic                   selftest_fail_i,
      // Firmware side: command list indices and events.
      input  wire logic [IDX_W-1:0]       list_in_index_i,
      input  wire logic [IDX_W-1:0]       status_out_index_i,
      input  wire logic [IDX_W-1:0]       list_block_count_i,
      input  wire logic [IDX_W-1:0]       status_block_count_i,
      input  wire logic                   list_start_i,
      input  wire logic                   list_stop_i,
      input  wire logic                   sel_area_written_i,
      // Firmware side: bus transfer and execution monitors.
      input  wire logic                   xfer_active_i,
      input  wire logic                   bus_error_i,
      input  wire logic                   cmd_busy_i,
      input  wire logic                   fw_fault_i,
      // Events and data towards the firmware.
      output logic [3*HOST_DATA_W-1:0]    addr_buffer_o,
      output logic                        single_cmd_go_o,
      output logic                        list_attn_o,
      output logic                        sel_ack_o,
      output logic                        board_reset_o,
      output logic                        scsi_bus_reset_o,
      output logic                        error_o
   );

   // Width of the synchronised pin bundle.
   localparam int unsigned PIN_W = 3 + HOST_ADDR_W + HOST_DATA_W;

   // Whole state of the block in one record.
   typedef struct packed
   {
      mode_t                                mode;         // Self-test, ready or failed.
      logic [31:0]                          st_cnt;       // Self-test duration counter.
      logic [7:0]                           stc;          // Self-test code shown during reset.
      logic                                 single_cmd_accept_toggle;          // Single command acceptance toggle.
      logic                                 err;          // Catastrophic error latched.
      logic [7:0]                           err_code;     // Code of the first error.
      logic                                 list_active;  // A command list is running.
      logic                                 sel_written;  // A selection area awaits host read.
      logic [31:0]                          wd_cnt;       // Transfer watchdog counter.
      logic                                 strobe_q;     // Previous accepted strobe level.
      logic                                 ack;          // Host acknowledge.
      logic                                 rd_oe;        // Host data bus driven.
      logic [HOST_DATA_W-1:0]               rd_data;      // Read data held on the bus.
      logic [2:0][HOST_DATA_W-1:0]          abuf;         // Address buffer words.
      logic [1:0]                           abuf_idx;     // Next address buffer word.
      logic                                 single_go;    // Single command pulse.
      logic                                 list_go;      // List attention pulse.
      logic                                 sel_ack;      // Selection acknowledge pulse.
      logic                                 core_rst;     // Board reset pulse.
      logic                                 scsi_rst;     // SCSI bus reset pulse.
   } state_t;

   // Value taken at power-up and after a reset port write.
   localparam state_t STATE_RST = '{mode: MODE_SELFTEST, stc: STC_POWERUP, default: '0};

   state_t                 s_r;          // Registered state.
   state_t                 s_nxt;        // Next state.
   logic [PIN_W-1:0]       pins_sync;    // Filtered pin bundle.
   logic                   strobe_s;     // Filtered host strobe.
   logic                   write_s;      // Filtered write qualifier.
   logic                   jumper_s;     // Filtered SCSI reset jumper.
   logic [HOST_ADDR_W-1:0] addr_s;       // Filtered host address.
   logic [HOST_DATA_W-1:0] data_s;       // Filtered host write data.

   // All host pins pass one shared synchroniser; address and data are stable long before the strobe.
   pin_sync
      #(
         .W (PIN_W)
      )
   u_pin_sync
      (
         .clk_sys_i (clk_sys_i),
         .rst_i     (rst_i),
         .pin_i     ({host_strobe_i, host_write_i, scsi_reset_jumper_i, host_addr_i, host_data_i}),
         .sync_o    (pins_sync)
      );

   assign {strobe_s, write_s, jumper_s, addr_s, data_s} = pins_sync;

   // Next-state logic for host accesses, self-test, list tracking and error latching.
   always_comb
   begin
      logic                   take;       // Host access taken this cycle.
      logic                   err_hit;    // Some error source fires.
      logic [7:0]             err_c;      // Code of the winning source.
      logic [1:0]             attn_type;  // Decoded attention type.
      logic [HOST_DATA_W-1:0] status;     // Status word as read now.
      logic                   ready;      // Normal operation.
      take      = strobe_s && !s_r.strobe_q;
      err_hit   = 1'b0;
      err_c     = 8'h00;
      attn_type = data_s[ATTN_TYPE_MSB:ATTN_TYPE_LSB];
      status    = '0;
      ready     = (s_r.mode == MODE_READY);

      s_nxt           = s_r;
      s_nxt.strobe_q  = strobe_s;
      s_nxt.single_go = 1'b0;
      s_nxt.list_go   = 1'b0;
      s_nxt.sel_ack   = 1'b0;
      s_nxt.core_rst  = 1'b0;
      s_nxt.scsi_rst  = 1'b0;

      // The acknowledge holds until the host lets go of the strobe.
      if (!strobe_s)
      begin
         s_nxt.ack   = 1'b0;
         s_nxt.rd_oe = 1'b0;
      end

      unique case (s_r.mode)
         MODE_SELFTEST:
         begin
            // Firmware reports each test as it starts.
            if (stc_we_i)
               s_nxt.stc = stc_code_i;
            if (s_r.st_cnt == SELFTEST_CYCLES - 32'h1)
               s_nxt.mode = selftest_fail_i ? MODE_FAILED : MODE_READY;
            else
               s_nxt.st_cnt = s_r.st_cnt + 32'h1;
         end
         MODE_READY:
         begin
            // Nothing leaves normal operation except a reset.
         end
         MODE_FAILED:
         begin
            // The failing test code stays visible until the next reset.
         end
      endcase

      if (ready && xfer_active_i)
      begin
         if (s_r.wd_cnt != XFER_TIMEOUT_CYCLES)
            s_nxt.wd_cnt = s_r.wd_cnt + 32'h1;
      end
      else
         s_nxt.wd_cnt = '0;

      // Error sources in fixed priority; the earliest listed wins a tie.
      if (ready)
      begin
         if (bus_error_i && xfer_active_i)
         begin
            err_hit = 1'b1;
            err_c   = ERRC_BUS_ERROR;
         end
         else if (s_r.wd_cnt == XFER_TIMEOUT_CYCLES - 32'h1)
         begin
            err_hit = 1'b1;
            err_c   = ERRC_BUS_TIMEOUT;
         end
         else if (fw_fault_i && cmd_busy_i)
         begin
            err_hit = 1'b1;
            err_c   = ERRC_FIRMWARE;
         end
         else if (s_r.list_active && ((list_in_index_i > list_block_count_i) ||
                  (status_out_index_i > status_block_count_i)))
         begin
            err_hit = 1'b1;
            err_c   = ERRC_BAD_INDEX;
         end
         else if ((list_start_i && s_r.list_active) || (list_stop_i && !s_r.list_active))
         begin
            err_hit = 1'b1;
            err_c   = ERRC_LIST_STATE;
         end

         // Track list state; a redundant start or stop leaves list_active unchanged.
         if (list_start_i)
            s_nxt.list_active = 1'b1;
         else if (list_stop_i)
            s_nxt.list_active = 1'b0;
      end

      if (ready)
      begin
         status[STAT_CODE_MSB:STAT_CODE_LSB] = s_r.err ? s_r.err_code : BOARD_TYPE;
         status[STAT_ERR_BIT]                = s_r.err;
         status[STAT_RDY_BIT]                = 1'b1;
         status[STAT_ENT_BIT]                = s_r.single_cmd_accept_toggle;
      end
      else
      begin
         // Reset format: code in bits 7..2 and 0, ready bit low.
         status[7:2] = s_r.stc[7:2];
         status[0]   = s_r.stc[0];
      end

      // Host access decode.
      if (take)
      begin
         s_nxt.ack = 1'b1;
         if (write_s)
         begin
            unique case (addr_s)
               OFS_ADDR_BUFFER:
               begin
                  // Three words per command; a fourth wraps onto the first.
                  s_nxt.abuf[s_r.abuf_idx] = data_s;
                  s_nxt.abuf_idx = (s_r.abuf_idx == ABUF_LAST_IDX) ? 2'h0 : s_r.abuf_idx + 2'h1;
               end
               OFS_ATTENTION:
               begin
                  // Attentions before ready are dropped; the host must not send them.
                  if (ready)
                  begin
                     unique case (attn_type)
                        ATTN_SINGLE:
                        begin
                           s_nxt.single_cmd_accept_toggle       = !s_r.single_cmd_accept_toggle;
                           s_nxt.single_go = 1'b1;
                           s_nxt.abuf_idx  = 2'h0;
                        end
                        ATTN_LIST:
                        begin
                           if (s_r.list_active)
                              s_nxt.list_go = 1'b1;
                           else if (!err_hit)
                           begin
                              err_hit = 1'b1;
                              err_c   = ERRC_LIST_STATE;
                           end
                        end
                        ATTN_SEL_ACK:
                        begin
                           if (s_r.sel_written)
                           begin
                              s_nxt.sel_ack     = 1'b1;
                              s_nxt.sel_written = 1'b0;
                           end
                           else if (!err_hit)
                           begin
                              err_hit = 1'b1;
                              err_c   = ERRC_TARGET_MODE;
                           end
                        end
                        default:
                        begin
                           // Type 11 has no meaning and is ignored.
                        end
                     endcase
                  end
               end
               default:
               begin
                  // Writes to the status word or unused offsets are acknowledged and dropped.
               end
            endcase
         end
         else
         begin
            s_nxt.rd_oe = 1'b1;
            s_nxt.rd_data = (addr_s == OFS_STATUS_WORD) ? status : '0;
         end
      end

      // A new selection area wins over a simultaneous acknowledge.
      if (sel_area_written_i && ready)
         s_nxt.sel_written = 1'b1;

      if (err_hit && !s_r.err)
      begin
         s_nxt.err      = 1'b1;
         s_nxt.err_code = err_c;
      end

      if (take && write_s && (addr_s == OFS_RESET_TRIGGER))
      begin
         s_nxt          = STATE_RST;
         s_nxt.strobe_q = 1'b1;
         s_nxt.ack      = 1'b1;
         s_nxt.core_rst = 1'b1;
         s_nxt.scsi_rst = jumper_s;
      end
   end

   // Register the whole state.
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         s_r <= STATE_RST;
      else
         s_r <= s_nxt;
   end

   // Outputs straight from the state flops.
   assign host_data_o      = s_r.rd_data;
   assign host_data_oe_o   = s_r.rd_oe;
   assign host_ack_o       = s_r.ack;
   assign addr_buffer_o    = s_r.abuf;
   assign single_cmd_go_o  = s_r.single_go;
   assign list_attn_o      = s_r.list_go;
   assign sel_ack_o        = s_r.sel_ack;
   assign board_reset_o    = s_r.core_rst;
   assign scsi_bus_reset_o = s_r.scsi_rst;
   assign error_o          = s_r.err;

endmodule : adapter_status_reset_ports

/* adapter_status_pkg.sv */
// Package holding offsets, field positions, codes and timing of the status and reset ports.
package adapter_status_pkg;

   // Host window width and data width of the ports.
   localparam int unsigned HOST_ADDR_W = 9;
   localparam int unsigned HOST_DATA_W = 16;

   // Port offsets inside the 512-byte host window.
   localparam logic [8:0] OFS_ADDR_BUFFER   = 9'h000;
   localparam logic [8:0] OFS_ATTENTION     = 9'h008;
   localparam logic [8:0] OFS_STATUS_WORD   = 9'h010;
   localparam logic [8:0] OFS_RESET_TRIGGER = 9'h018;

   // Number of words the address buffer port takes per single command.
   localparam logic [1:0] ABUF_WORDS     = 2'h3;
   localparam logic [1:0] ABUF_LAST_IDX  = 2'h2;

   // Channel attention type field, bits [1:0] of the written data.
   localparam int unsigned ATTN_TYPE_LSB = 0;
   localparam int unsigned ATTN_TYPE_MSB = 1;
   localparam logic [1:0] ATTN_SINGLE    = 2'h0;
   localparam logic [1:0] ATTN_LIST      = 2'h1;
   localparam logic [1:0] ATTN_SEL_ACK   = 2'h2;

   // General status format field positions.
   localparam int unsigned STAT_ENT_BIT  = 0;
   localparam int unsigned STAT_RDY_BIT  = 1;
   localparam int unsigned STAT_ERR_BIT  = 4;
   localparam int unsigned STAT_CODE_LSB = 8;
   localparam int unsigned STAT_CODE_MSB = 15;

   // Self-test code shown right after reset, before firmware writes any code.
   localparam logic [7:0] STC_POWERUP = 8'hfd;

   // Catastrophic error codes.
   localparam logic [7:0] ERRC_BAD_INDEX   = 8'h10;
   localparam logic [7:0] ERRC_LIST_STATE  = 8'h11;
   localparam logic [7:0] ERRC_TARGET_MODE = 8'h12;
   localparam logic [7:0] ERRC_BUS_TIMEOUT = 8'h14;
   localparam logic [7:0] ERRC_BUS_ERROR   = 8'h15;
   localparam logic [7:0] ERRC_FIRMWARE    = 8'h96;

   // Clock period and timing figures.
   localparam longint unsigned CLK_PERIOD_NS     = 64'd5;
   localparam longint unsigned SELFTEST_TIME_S   = 64'd5;
   localparam longint unsigned XFER_TIMEOUT_US   = 64'd100;
   localparam logic [31:0] SELFTEST_CYCLES_DEF =
      32'(SELFTEST_TIME_S * 64'd1000000000 / CLK_PERIOD_NS);
   localparam logic [31:0] XFER_TIMEOUT_CYCLES_DEF =
      32'(XFER_TIMEOUT_US * 64'd1000 / CLK_PERIOD_NS);

   // Board operating mode, one-hot.
   typedef enum logic [2:0]
   {
      MODE_SELFTEST = 3'b001,
      MODE_READY    = 3'b010,
      MODE_FAILED   = 3'b100
   } mode_t;

endpackage : adapter_status_pkg

/* pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pin inputs.
`timescale 1ns/100ps
module pin_sync
   #(
      parameter int unsigned W = 1
   )
   (
      // Clock and reset.
      input  wire logic         clk_sys_i,
      input  wire logic         rst_i,
      // Asynchronous pins and their filtered copy.
      input  wire logic [W-1:0] pin_i,
      output logic      [W-1:0] sync_o
   );

   // All flops of the chain in one record.
   typedef struct packed
   {
      logic [W-1:0] s1;   // Metastability catcher, read only by s2.
      logic [W-1:0] s2;   // Second stage.
      logic [W-1:0] s3;   // Third stage.
      logic [W-1:0] q;    // Accepted value.
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   // Shift the chain; a bit is accepted only once stages two and three agree.
   always_comb
   begin
      s_nxt    = s_r;
      s_nxt.s1 = pin_i;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.q  = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.q & (s_r.s2 ^ s_r.s3));
   end

   // Register the chain.
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign sync_o = s_r.q;

endmodule : pin_sync

/* adapter_status_checker.sv */
// Port-level assertions for the adapter status and reset ports.
`timescale 1ns/100ps
module adapter_status_checker
   import adapter_status_pkg::*;
   (
      // Clock and reset.
      input wire logic        clk_sys_i,
      input wire logic        rst_i,
      // Host port.
      input wire logic        host_strobe_i,
      input wire logic        host_write_i,
      input wire logic [8:0]  host_addr_i,
      input wire logic [15:0] host_data_i,
      input wire logic [15:0] host_data_o,
      input wire logic        host_ack_o,
      // Jumper and events.
      input wire logic        scsi_reset_jumper_i,
      input wire logic        single_cmd_go_o,
      input wire logic        list_attn_o,
      input wire logic        sel_ack_o,
      input wire logic        board_reset_o,
      input wire logic        scsi_bus_reset_o,
      input wire logic        error_o
   );
   // All checks share the board clock; reset silences them.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_GO_SINGLE: assert property (
      single_cmd_go_o |-> host_write_i && host_addr_i == OFS_ATTENTION && host_data_i[1:0] == ATTN_SINGLE)
      else $error("single go without single attention write");
   AST_GO_ONCE: assert property (
      single_cmd_go_o |=> !single_cmd_go_o [*3]) else $error("single go repeated");
   AST_LIST_ATTN: assert property (
      list_attn_o |-> host_write_i && host_addr_i == OFS_ATTENTION && host_data_i[1:0] == ATTN_LIST)
      else $error("list attention without list write");
   AST_SEL_ACK: assert property (
      sel_ack_o |-> host_write_i && host_addr_i == OFS_ATTENTION && host_data_i[1:0] == ATTN_SEL_ACK)
      else $error("selection ack without ack write");
   AST_READ_ZERO: assert property (
      $rose(host_ack_o) && !host_write_i && host_addr_i != OFS_STATUS_WORD |-> host_data_o == 16'h0000)
      else $error("read of other offset not zero");
   AST_ACK_STANDS: assert property (
      host_ack_o && host_strobe_i |=> host_ack_o) else $error("ack dropped while strobe held");
   AST_ACK_CAUSE: assert property (
      $rose(host_ack_o) |-> host_strobe_i && $past(host_strobe_i, 2)) else $error("ack without strobe");
   AST_RESET_WRITE: assert property (
      board_reset_o |-> host_write_i && host_addr_i == OFS_RESET_TRIGGER) else $error("board reset without write");
   AST_SCSI_JUMPER: assert property (
      board_reset_o |-> scsi_bus_reset_o == scsi_reset_jumper_i) else $error("scsi reset not per jumper");
   AST_ERR_LATCH: assert property (
      $fell(error_o) |-> board_reset_o || $past(board_reset_o) || $past(board_reset_o, 2))
      else $error("error flag cleared without reset");
   // Main scenarios seen at least once.
   CV_GO: cover property (single_cmd_go_o);
   CV_LIST: cover property (list_attn_o);
   CV_SCSI: cover property (board_reset_o && scsi_bus_reset_o);
endmodule : adapter_status_checker

bind adapter_status_reset_ports adapter_status_checker checker_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .host_strobe_i(host_strobe_i), .host_write_i(host_write_i), .host_addr_i(host_addr_i),
   .host_data_i(host_data_i), .host_data_o(host_data_o), .host_ack_o(host_ack_o),
   .scsi_reset_jumper_i(scsi_reset_jumper_i), .single_cmd_go_o(single_cmd_go_o), .list_attn_o(list_attn_o),
   .sel_ack_o(sel_ack_o), .board_reset_o(board_reset_o), .scsi_bus_reset_o(scsi_bus_reset_o), .error_o(error_o));

/* host_model.sv */
// Host bus master model driving the strobe handshake of the host port.
`timescale 1ns/100ps
module host_model
   (
      // Clock and answer from the board.
      input  wire logic        clk_sys_i,
      input  wire logic        ack_i,
      input  wire logic [15:0] rd_i,
      // Request lines towards the board.
      output logic             strobe_o,
      output logic             write_o,
      output logic [8:0]       addr_o,
      output logic [15:0]      wd_o
   );
   logic        hung  = 1'b0;  // Set when the board never answers.
   logic [15:0] rdata = '0;    // Data taken at the answering edge.
   initial
   begin
      strobe_o = 1'b0;
      write_o  = 1'b0;
      addr_o   = '0;
      wd_o     = '0;
   end
   // One access: hold everything until ack is sampled, then release.
   task access(input logic w, input logic [8:0] a, input logic [15:0] d);
      int n;
      @(posedge clk_sys_i);
      #1;
      strobe_o = 1'b1;
      write_o  = w;
      addr_o   = a;
      wd_o     = d;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (ack_i !== 1'b1 && n < 40);
      rdata = rd_i;
      #1;
      strobe_o = 1'b0;
      // Released data shows the inverse so stale values cannot pass.
      wd_o = ~d;
      while (ack_i !== 1'b0 && n < 80)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 40)
         hung = 1'b1;
      repeat (5) @(posedge clk_sys_i);
      #1;
   endtask : access
endmodule : host_model

/* tb_top.sv */
// Self-checking bench for the adapter status and reset ports.
`timescale 1ns/100ps
module tb_top;
   import adapter_status_pkg::*;
   logic        clk_sys_i, rst_i, jmp, fail, li_st, li_sp, area, xfer, berr, busy, fault;
   logic [7:0]  li, lb, code, so, sb;
   logic [15:0] hd_o, hd_i, w[3], e;
   logic [8:0]  ha;
   logic        hs, hw, oe, ack, go, la, sa, br, sr, err, ack_q = 1'b0;
   logic [47:0] abuf;
   logic [15:0] expq[$];
   logic [7:0]  codes[6] = '{ERRC_BAD_INDEX, ERRC_LIST_STATE, ERRC_TARGET_MODE,
                             ERRC_BUS_TIMEOUT, ERRC_BUS_ERROR, ERRC_FIRMWARE};
   int          fail_count = 0, checks_done = 0, seed = 51, nbr = 0, nsr = 0, ngo = 0, nla = 0, nsa = 0;
   // Short self-test and timeout keep the run brief.
   adapter_status_reset_ports #(.SELFTEST_CYCLES(32'd50), .XFER_TIMEOUT_CYCLES(32'd20))
      adapter_status_reset_ports_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_strobe_i(hs),
      .host_write_i(hw), .host_addr_i(ha), .host_data_i(hd_i), .host_data_o(hd_o), .host_data_oe_o(oe),
      .host_ack_o(ack), .scsi_reset_jumper_i(jmp), .stc_we_i(1'b0), .stc_code_i(8'h00),
      .selftest_fail_i(fail), .list_in_index_i(li), .status_out_index_i(so), .list_block_count_i(lb),
      .status_block_count_i(sb), .list_start_i(li_st), .list_stop_i(li_sp), .sel_area_written_i(area),
      .xfer_active_i(xfer), .bus_error_i(berr), .cmd_busy_i(busy), .fw_fault_i(fault), .addr_buffer_o(abuf),
      .single_cmd_go_o(go), .list_attn_o(la), .sel_ack_o(sa), .board_reset_o(br), .scsi_bus_reset_o(sr),
      .error_o(err));
   host_model host_model_inst (.clk_sys_i(clk_sys_i), .ack_i(ack), .rd_i(hd_o), .strobe_o(hs), .write_o(hw),
      .addr_o(ha), .wd_o(hd_i));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task results;
      $display("mismatches %0d checks %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse
   // A read notes its expected word before the access starts.
   task rd16(input logic [8:0] a, input logic [15:0] x);
      expq.push_back(x);
      host_model_inst.access(1'b0, a, 16'h0000);
   endtask : rd16
   // Watcher: each fresh read answer is compared with the oldest note.
   always @(posedge clk_sys_i)
   begin
      ack_q <= ack;
      if (ack === 1'b1 && ack_q !== 1'b1 && hw === 1'b0)
      begin
         chk("read data", hd_o, expq.pop_front());
         chk("read enable", 48'(oe), 48'd1);
      end
      // One-cycle event pulses are counted for the closing checks.
      ngo += int'(go === 1'b1);
      nla += int'(la === 1'b1);
      nsa += int'(sa === 1'b1);
      if (br === 1'b1)
         nbr++;
      if (sr === 1'b1)
         nsr++;
   end
   // A hung handshake ends the run as a failure.
   always @(posedge host_model_inst.hung)
   begin
      fail_count++;
      results();
   end
   initial
   begin
      rst_i = 1'b1;
      {jmp, fail, li_st, li_sp, area, xfer, berr, busy, fault} = '0;
      li = 8'h00;
      lb = 8'h04;
      so = 8'h00;
      sb = 8'h04;
      cyc(3);
      rst_i = 1'b0;
      rd16(OFS_STATUS_WORD, 16'h00fd);
      cyc(60);
      rd16(OFS_STATUS_WORD, 16'h5a02);
      for (int i = 0; i < 3; i++)
      begin
         w[i] = 16'($random(seed));
         host_model_inst.access(1'b1, OFS_ADDR_BUFFER, w[i]);
      end
      chk("address buffer", abuf, {w[2], w[1], w[0]});
      host_model_inst.access(1'b1, OFS_ATTENTION, 16'h0000);
      rd16(OFS_STATUS_WORD, 16'h5a03);
      pulse(li_st);
      host_model_inst.access(1'b1, OFS_ATTENTION, 16'h0001);
      rd16(OFS_STATUS_WORD, 16'h5a03);
      pulse(area);
      host_model_inst.access(1'b1, OFS_ATTENTION, 16'h0002);
      // Type 11 has no meaning: the next status read must show it changed nothing.
      host_model_inst.access(1'b1, OFS_ATTENTION, 16'h0003);
      host_model_inst.access(1'b1, OFS_ATTENTION, 16'h0000);
      rd16(OFS_STATUS_WORD, 16'h5a02);
      host_model_inst.access(1'b1, OFS_STATUS_WORD, 16'($random(seed)));
      rd16(9'h004, 16'h0000);
      // Reset port: any data, jumper off then on.
      host_model_inst.access(1'b1, OFS_RESET_TRIGGER, 16'($random(seed)));
      jmp = 1'b1;
      cyc(8);
      host_model_inst.access(1'b1, OFS_RESET_TRIGGER, 16'($random(seed)));
      rd16(OFS_STATUS_WORD, 16'h00fd);
      chk("board resets", 48'(nbr), 48'd2);
      chk("scsi resets", 48'(nsr), 48'd1);
      // Each catastrophic cause after a fresh boot, last one a failed self-test.
      for (int k = 0; k < 8; k++)
      begin
         rst_i = 1'b1;
         fail = (k == 7);
         cyc(3);
         rst_i = 1'b0;
         cyc(60);
         case (k)
            0: begin li = 8'h05; pulse(li_st); end
            1: pulse(li_sp);
            2: host_model_inst.access(1'b1, OFS_ATTENTION, 16'h0002);
            3: begin xfer = 1'b1; cyc(25); xfer = 1'b0; end
            4: begin xfer = 1'b1; berr = 1'b1; cyc(1); {xfer, berr} = '0; end
            5: begin busy = 1'b1; pulse(fault); busy = 1'b0; end
            6: begin so = 8'h05; pulse(li_st); end
            default: ;
         endcase
         code = (k < 6) ? codes[k] : ERRC_BAD_INDEX;
         e = (k == 7) ? 16'h00fd : {code, 8'h12};
         rd16(OFS_STATUS_WORD, e);
         chk("error flag", 48'(err), 48'(k < 7));
         busy = 1'b1;
         pulse(fault);
         busy = 1'b0;
         li = 8'h00;
         so = 8'h00;
         rd16(OFS_STATUS_WORD, e);
         // Besides rst_i, a reset port write is the only thing that may clear a latched error.
         if (k < 7)
         begin
            host_model_inst.access(1'b1, OFS_RESET_TRIGGER, 16'($random(seed)));
            chk("error cleared", 48'(err), 48'd0);
         end
      end
      chk("single go", 48'(ngo), 48'd2);
      chk("list attention", 48'(nla), 48'd1);
      chk("selection ack", 48'(nsa), 48'd1);
      chk("notes left", 48'(expq.size()), 48'd0);
      results();
   end
endmodule : tb_top
